// [core/fcp_top.sv]
// Four-channel PWM generator with APB register slave
//
// What this block does
// - Four channels, each a 16-bit up/down counter, period and width with shadows.
// - Block runs only while both configuration enable bits 2 and 4 are set.
// - Registers decode only inside the EC00h to ECFFh index window.
// - Each pin is its channel output XOR its polarity bit, cleared at reset.
// - Edge mode counts up to period shadow, then wraps to zero.
// - Edge mode output high while counter at or above width shadow.
// - Edge mode period is period shadow plus one ticks.
// - Width zero gives constant high; width above period gives constant low.
// - Center mode counts up to period, reverses, down to zero, reverses.
// - Center mode rises counting up at width, falls counting down below it.
// - Center mode period is twice period shadow plus two ticks.
// - Burst bit puts channel 0 AND channel 1 on pin 0; pin 1 unchanged.
// - Burst AND result is registered onto pin 0, free of glitches.
// - Polarity XOR is applied after the burst AND.
// - In burst, channels 0 and 1 keep their own alignment modes.
// - Single shot exists only on channels 2 and 3, per select bit.
// - Single shot clears counter and run bit on count after period match.
// - Single shot output high at or above width, low once cleared.
// - Counter writes take effect at once, moving pending edges.
// - Writing the period shadow value to a running single shot's counter ends it next clock.
// - Each counter ticks at clock rate or clock divided by 64.
// - Shadows load at each cycle start or on write while stopped.
// - Run bit gates the counter tick and direct shadow loads on write; software sets it.
// - Disabled output keeps pin off the PWM signal; pending flags still set.
module fcp_top #(
  parameter int DIV = fcp_pkg::DIV_DEFAULT
) (
  input  wire logic                     REF_CLK,
  input  wire logic                     RESET_N,
  input  wire logic                     PSEL,
  input  wire logic                     PENABLE,
  input  wire logic                     PWRITE,
  input  wire logic [17:0]              PADDR,
  input  wire logic [31:0]              PWDATA,
  output logic      [31:0]              PRDATA,
  output logic                          PREADY,
  output logic                          PSLVERR,
  output logic      [fcp_pkg::NCH-1:0]  PWM_OUT
);

  if (DIV != 64) begin : g_div_check
    $error("fcp_top: prescaler must be 64");
  end

  fcp_pkg::fcp_state_s state;
  fcp_pkg::fcp_state_s next_state;
  logic                rst_meta;
  logic                rst_n;

  // Reset release synchroniser
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Address decode of a word index
  function automatic fcp_pkg::fcp_sel_s decode(input logic [15:0] idx);
    fcp_pkg::fcp_sel_s sel;
    sel.kind = fcp_pkg::FCP_K_NONE;
    sel.ch   = idx[2:1];
    if (idx[15:8] == fcp_pkg::WIN_HIGH) begin
      if (idx[7:0] == fcp_pkg::OFF_CON0) begin
        sel.kind = fcp_pkg::FCP_K_CON0;
      end else if (idx[7:0] == fcp_pkg::OFF_CON1) begin
        sel.kind = fcp_pkg::FCP_K_CON1;
      end else if (idx[7:0] == fcp_pkg::OFF_POL) begin
        sel.kind = fcp_pkg::FCP_K_POL;
      end else if (idx[7:0] == fcp_pkg::OFF_ENA) begin
        sel.kind = fcp_pkg::FCP_K_ENA;
      end else if (idx[3] == 1'b0 && idx[0] == 1'b0) begin
        if (idx[7:4] == fcp_pkg::GRP_CNT) begin
          sel.kind = fcp_pkg::FCP_K_CNT;
        end else if (idx[7:4] == fcp_pkg::GRP_PER) begin
          sel.kind = fcp_pkg::FCP_K_PER;
        end else if (idx[7:4] == fcp_pkg::GRP_PW) begin
          sel.kind = fcp_pkg::FCP_K_PW;
        end
      end
    end
    return sel;
  endfunction : decode

  always_comb begin
    fcp_pkg::fcp_sel_s sel;
    logic              active;
    logic              pre_tc;
    logic              tick;
    logic              ss;
    logic              start;
    logic              wr;
    logic [15:0]       wd;
    logic [15:0]       rd;
    logic [fcp_pkg::NCH-1:0] raw;
    logic [fcp_pkg::NCH-1:0] irq_set;
    logic [fcp_pkg::NCH-1:0] chan;
    sel        = decode(PADDR[17:2]);
    active     = 1'b0;
    pre_tc     = 1'b0;
    tick       = 1'b0;
    ss         = 1'b0;
    start      = 1'b0;
    wr         = 1'b0;
    wd         = PWDATA[15:0];
    rd         = fcp_pkg::RST_VALUE;
    raw        = '0;
    irq_set    = '0;
    chan       = '0;
    next_state = state;

    active = state.ena[fcp_pkg::ENA_SYS_BIT] & state.ena[fcp_pkg::ENA_PER_BIT];
    pre_tc = (state.pre == 6'(DIV - 1));
    if (active) begin
      next_state.pre = pre_tc ? 6'h00 : state.pre + 6'h01;
    end else begin
      next_state.pre = 6'h00;
    end

    for (int i = 0; i < fcp_pkg::NCH; i++) begin
      raw[i] = (state.cnt[i] >= state.pw_sh[i]);
      tick   = active & state.run[i] & (~state.div[i] | pre_tc);
      ss     = (i >= 2) && state.con1[fcp_pkg::CON1_SS_LSB + i];
      start  = 1'b0;
      if (ss && state.run[i] && state.abort[i]) begin
        next_state.cnt[i]   = fcp_pkg::RST_VALUE;
        next_state.run[i]   = 1'b0;
        next_state.abort[i] = 1'b0;
        start               = 1'b1;
      end else if (tick) begin
        if (ss || !state.con1[fcp_pkg::CON1_ALN_LSB + i]) begin
          if (state.cnt[i] == state.per_sh[i]) begin
            next_state.cnt[i] = fcp_pkg::RST_VALUE;
            start             = 1'b1;
            if (ss) begin
              next_state.run[i] = 1'b0;
            end
          end else begin
            next_state.cnt[i] = state.cnt[i] + 16'h0001;
          end
        end else if (!state.down[i]) begin
          if (state.cnt[i] == state.per_sh[i]) begin
            next_state.down[i] = 1'b1;
          end else begin
            next_state.cnt[i] = state.cnt[i] + 16'h0001;
          end
        end else begin
          if (state.cnt[i] == fcp_pkg::RST_VALUE) begin
            next_state.down[i] = 1'b0;
            start              = 1'b1;
          end else begin
            next_state.cnt[i] = state.cnt[i] - 16'h0001;
          end
        end
      end
      if (!ss || !state.run[i]) begin
        next_state.abort[i] = 1'b0;
      end
      if (start) begin
        next_state.per_sh[i] = state.per[i];
        next_state.pw_sh[i]  = state.pw[i];
        irq_set[i]           = 1'b1;
      end
    end

    // Burst combine, then output enable, then polarity, all registered
    chan = raw;
    if (state.con1[fcp_pkg::CON1_BURST]) begin
      chan[0] = raw[0] & raw[1];
    end
    for (int i = 0; i < fcp_pkg::NCH; i++) begin
      if (state.con1[fcp_pkg::CON1_OE_LSB + i]) begin
        next_state.pins[i] = chan[i] ^ state.pol[i];
      end else begin
        next_state.pins[i] = state.pol[i];
      end
    end

    // APB read data and error, registered with pready
    unique case (sel.kind)
      fcp_pkg::FCP_K_CON0: rd = {state.irq, state.ie, state.div, state.run};
      fcp_pkg::FCP_K_CON1: rd = state.con1;
      fcp_pkg::FCP_K_POL:  rd = {12'h000, state.pol};
      fcp_pkg::FCP_K_ENA:  rd = state.ena;
      fcp_pkg::FCP_K_CNT:  rd = state.cnt[sel.ch];
      fcp_pkg::FCP_K_PER:  rd = state.per[sel.ch];
      fcp_pkg::FCP_K_PW:   rd = state.pw[sel.ch];
      fcp_pkg::FCP_K_NONE: rd = fcp_pkg::RST_VALUE;
    endcase
    if (PSEL && PENABLE && !state.pready) begin
      next_state.pready  = 1'b1;
      next_state.pslverr = (sel.kind == fcp_pkg::FCP_K_NONE);
      next_state.prdata  = {16'h0000, rd};
    end else begin
      next_state.pready  = 1'b0;
      next_state.pslverr = 1'b0;
      next_state.prdata  = 32'h0000_0000;
    end
    wr = PSEL & PENABLE & PWRITE & state.pready & ~state.pslverr;

    if (wr) begin
      unique case (sel.kind)
        fcp_pkg::FCP_K_CON0: begin
          next_state.run = wd[fcp_pkg::CON0_RUN_LSB +: fcp_pkg::NCH];
          next_state.div = wd[fcp_pkg::CON0_DIV_LSB +: fcp_pkg::NCH];
          next_state.ie  = wd[fcp_pkg::CON0_IE_LSB +: fcp_pkg::NCH];
        end
        fcp_pkg::FCP_K_CON1: next_state.con1 = wd & fcp_pkg::CON1_MASK;
        fcp_pkg::FCP_K_POL:  next_state.pol  = wd[fcp_pkg::NCH-1:0];
        fcp_pkg::FCP_K_ENA:  next_state.ena  = wd & fcp_pkg::ENA_MASK;
        fcp_pkg::FCP_K_CNT: begin
          next_state.cnt[sel.ch] = wd;
          if (sel.ch[1] && state.con1[fcp_pkg::CON1_SS_LSB + 32'(sel.ch)]
              && state.run[sel.ch] && wd == state.per_sh[sel.ch]) begin
            next_state.abort[sel.ch] = 1'b1;
          end
        end
        fcp_pkg::FCP_K_PER: begin
          next_state.per[sel.ch] = wd;
          if (!state.run[sel.ch]) begin
            next_state.per_sh[sel.ch] = wd;
          end
        end
        fcp_pkg::FCP_K_PW: begin
          next_state.pw[sel.ch] = wd;
          if (!state.run[sel.ch]) begin
            next_state.pw_sh[sel.ch] = wd;
          end
        end
        fcp_pkg::FCP_K_NONE: begin
        end
      endcase
    end

    // Pending flags: hardware set wins over a software clear
    if (wr && sel.kind == fcp_pkg::FCP_K_CON0) begin
      next_state.irq = wd[fcp_pkg::CON0_IRQ_LSB +: fcp_pkg::NCH] | irq_set;
    end else begin
      next_state.irq = state.irq | irq_set;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign PRDATA  = state.prdata;
  assign PREADY  = state.pready;
  assign PSLVERR = state.pslverr;
  assign PWM_OUT = state.pins;

endmodule : fcp_top

// [core/fcp_pkg.sv]
// Constants, field layout and carrier types of the four-channel PWM generator
package fcp_pkg;

  localparam int          NCH           = 4;
  localparam int          CW            = 16;
  localparam int          DIV_DEFAULT   = 64;

  // Register indices within the window, byte address is four times the index
  localparam logic [7:0]  WIN_HIGH      = 8'hEC;
  localparam logic [7:0]  OFF_CON0      = 8'h00;
  localparam logic [7:0]  OFF_CON1      = 8'h02;
  localparam logic [7:0]  OFF_POL       = 8'h04;
  localparam logic [7:0]  OFF_ENA       = 8'h06;
  localparam logic [3:0]  GRP_CNT       = 4'h1;
  localparam logic [3:0]  GRP_PER       = 4'h2;
  localparam logic [3:0]  GRP_PW        = 4'h3;

  // Field positions of run_and_irq_control
  localparam int          CON0_RUN_LSB  = 0;
  localparam int          CON0_DIV_LSB  = 4;
  localparam int          CON0_IE_LSB   = 8;
  localparam int          CON0_IRQ_LSB  = 12;

  // Field positions of mode_and_output_control
  localparam int          CON1_OE_LSB   = 0;
  localparam int          CON1_ALN_LSB  = 4;
  localparam int          CON1_BURST    = 12;
  localparam int          CON1_SS_LSB   = 12;
  localparam logic [15:0] CON1_MASK     = 16'hD0FF;

  // Enable bits of the configuration register
  localparam int          ENA_SYS_BIT   = 2;
  localparam int          ENA_PER_BIT   = 4;
  localparam logic [15:0] ENA_MASK      = 16'h0014;

  localparam logic [15:0] RST_VALUE     = 16'h0000;

  typedef enum logic [2:0] {
    FCP_K_NONE = 3'h0,
    FCP_K_CON0 = 3'h1,
    FCP_K_CON1 = 3'h3,
    FCP_K_POL  = 3'h2,
    FCP_K_ENA  = 3'h6,
    FCP_K_CNT  = 3'h7,
    FCP_K_PER  = 3'h5,
    FCP_K_PW   = 3'h4
  } fcp_kind_e;

  typedef struct packed {
    fcp_kind_e  kind;
    logic [1:0] ch;
  } fcp_sel_s;

  typedef struct packed {
    logic [NCH-1:0][CW-1:0] cnt;
    logic [NCH-1:0][CW-1:0] per;
    logic [NCH-1:0][CW-1:0] per_sh;
    logic [NCH-1:0][CW-1:0] pw;
    logic [NCH-1:0][CW-1:0] pw_sh;
    logic [NCH-1:0]         down;
    logic [NCH-1:0]         abort;
    logic [NCH-1:0]         run;
    logic [NCH-1:0]         div;
    logic [NCH-1:0]         ie;
    logic [NCH-1:0]         irq;
    logic [15:0]            con1;
    logic [NCH-1:0]         pol;
    logic [15:0]            ena;
    logic [5:0]             pre;
    logic [NCH-1:0]         pins;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
  } fcp_state_s;

endpackage : fcp_pkg

// [tb/fcp_chk.sv]
// Port checker of the PWM generator register slave
module fcp_chk #(
  parameter int DIV = fcp_pkg::DIV_DEFAULT
) (
  input wire logic                    REF_CLK,
  input wire logic                    RESET_N,
  input wire logic                    PSEL,
  input wire logic                    PENABLE,
  input wire logic                    PWRITE,
  input wire logic [17:0]             PADDR,
  input wire logic [31:0]             PWDATA,
  input wire logic [31:0]             PRDATA,
  input wire logic                    PREADY,
  input wire logic                    PSLVERR,
  input wire logic [fcp_pkg::NCH-1:0] PWM_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  sequence first_acc;
    PSEL && PENABLE && !$past(PENABLE);
  endsequence
  sequence done_acc;
    PSEL && PENABLE && PREADY;
  endsequence
  AST_ANSWER: assert property (first_acc |=> PREADY)
    else $error("Ready missing in second access cycle");
  AST_NOT_EARLY: assert property (first_acc |-> !PREADY)
    else $error("Ready in first access cycle");
  AST_ONE_PULSE: assert property (PREADY |=> !PREADY)
    else $error("Ready longer than one cycle");
  AST_QUALIFIED: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE))
    else $error("Ready outside an access phase");
  AST_ERR_READY: assert property (PSLVERR |-> PREADY)
    else $error("Error flag without ready");
  AST_OUTSIDE: assert property (done_acc ##0 (PADDR[17:10] != 8'hEC) |-> PSLVERR)
    else $error("Address outside window accepted");
  AST_ERR_DATA: assert property (PSLVERR |-> PRDATA == 32'h0)
    else $error("Refused access returned data");
  AST_IDLE_DATA: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("Read data outside answer cycle");
  AST_HIGH_HALF: assert property (PREADY |-> PRDATA[31:16] == 16'h0)
    else $error("Upper read half not zero");
endmodule : fcp_chk

bind fcp_top fcp_chk #(.DIV(DIV)) fcp_chk_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PWM_OUT(PWM_OUT));

// [tb/fcp_test.sv]
// Self-checking bench of the four-channel PWM generator
module fcp_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        REF_CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [17:0] PADDR = 18'h00000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  logic [3:0]  PWM_OUT;
  logic [31:0] rdat;
  logic        rerr;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;
  int          hi;
  int          rs;
  // Index, write data, read back, refused
  localparam logic [48:0] ROWS [8] = '{
    {16'hEC00, 16'h0F00, 16'h0F00, 1'b0}, {16'hEC02, 16'hFFFF, 16'hD0FF, 1'b0},
    {16'hEC04, 16'hFFFF, 16'h000F, 1'b0}, {16'hEC06, 16'h0010, 16'h0010, 1'b0},
    {16'hEC10, 16'h1234, 16'h1234, 1'b0}, {16'hEC22, 16'hABCD, 16'hABCD, 1'b0},
    {16'hEC36, 16'h00FF, 16'h00FF, 1'b0}, {16'hED00, 16'h5555, 16'h0000, 1'b1}};
  localparam logic [15:0] EW [3] = '{16'h0000, 16'h0004, 16'h0002};
  localparam logic [31:0] EH [3] = '{32'h10, 32'h0, 32'h8};

  fcp_top #(.DIV(64)) fcp_top_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PWM_OUT(PWM_OUT));

  always #20 REF_CLK = ~REF_CLK;

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= {idx, 2'b00};
    PWDATA <= {16'h0000, wd};
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'b1);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  // Counter, period and width of one channel
  task automatic chan(input logic [1:0] c, input logic [15:0] p, input logic [15:0] w);
    apb(1'b1, 16'hEC10 + {13'h0, c, 1'b0}, 16'h0000);
    apb(1'b1, 16'hEC20 + {13'h0, c, 1'b0}, p);
    apb(1'b1, 16'hEC30 + {13'h0, c, 1'b0}, w);
  endtask : chan

  // High cycles and rising edges of one pin
  task automatic meas(input int c, input int n);
    logic p;
    hi = 0;
    rs = 0;
    repeat (4) @(posedge REF_CLK);
    p = PWM_OUT[c];
    repeat (n) begin
      @(posedge REF_CLK);
      if (PWM_OUT[c] === 1'b1) hi++;
      if (PWM_OUT[c] === 1'b1 && p === 1'b0) rs++;
      p = PWM_OUT[c];
    end
  endtask : meas

  initial begin
    repeat (3) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ROWS[i][48:33], ROWS[i][32:17]);
      apb(1'b0, ROWS[i][48:33], 16'h0000);
      chk(rdat, {16'h0000, ROWS[i][16:1]});
      chk({31'h0, rerr}, {31'h0, ROWS[i][0]});
    end
    $display("Register rows done");
    RESET_N <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    apb(1'b0, 16'hEC10, 16'h0000);
    chk(rdat, 32'h0);
    apb(1'b0, 16'hEC22, 16'h0000);
    chk(rdat, 32'h0);
    apb(1'b0, 16'hEC04, 16'h0000);
    chk(rdat, 32'h0);
    chk({28'h0, PWM_OUT}, 32'h0);
    $display("Reset test done");
    apb(1'b1, 16'hEC02, 16'h0001);
    apb(1'b1, 16'hEC06, 16'h0014);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 16'hEC00, 16'h0000);
      chan(2'd0, 16'h0003, EW[i]);
      apb(1'b1, 16'hEC00, 16'h0001);
      meas(0, 16);
      chk(32'(hi), EH[i]);
    end
    chk(32'(rs), 32'h4);
    apb(1'b1, 16'hEC00, 16'h0000);
    chan(2'd1, 16'h0003, 16'h0002);
    apb(1'b1, 16'hEC02, 16'h0022);
    apb(1'b1, 16'hEC00, 16'h0002);
    meas(1, 16);
    chk(32'(hi), 32'h8);
    chk(32'(rs), 32'h2);
    $display("Alignment test done");
    apb(1'b1, 16'hEC00, 16'h0000);
    chan(2'd0, 16'h0003, 16'h0002);
    chan(2'd1, 16'h0003, 16'h0003);
    apb(1'b1, 16'hEC02, 16'h1023);
    apb(1'b1, 16'hEC00, 16'h0003);
    meas(0, 16);
    chk(32'(hi), 32'h2);
    apb(1'b1, 16'hEC04, 16'h0001);
    meas(0, 16);
    chk(32'(hi), 32'hE);
    meas(1, 16);
    chk(32'(hi), 32'h4);
    $display("Burst test done");
    apb(1'b1, 16'hEC04, 16'h0000);
    apb(1'b1, 16'hEC00, 16'h0000);
    chan(2'd2, 16'h0009, 16'h0006);
    apb(1'b1, 16'hEC02, 16'h4004);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, 16'hEC00, 16'h0004);
      meas(2, 24);
      chk(32'(hi), 32'h4);
      apb(1'b0, 16'hEC00, 16'h0000);
      chk({31'h0, rdat[2]}, 32'h0);
      chk({31'h0, rdat[14]}, 32'h1);
    end
    chan(2'd2, 16'h0100, 16'h0100);
    apb(1'b1, 16'hEC00, 16'h0044);
    apb(1'b1, 16'hEC14, 16'h0100);
    apb(1'b0, 16'hEC00, 16'h0000);
    chk({31'h0, rdat[2]}, 32'h0);
    apb(1'b0, 16'hEC14, 16'h0000);
    chk(rdat, 32'h0);
    $display("Single shot test done");
    chan(2'd3, 16'h0001, 16'h0001);
    apb(1'b1, 16'hEC02, 16'h0008);
    apb(1'b1, 16'hEC00, 16'h0088);
    meas(3, 256);
    chk(32'(hi), 32'h80);
    chk(32'(rs), 32'h2);
    apb(1'b1, 16'hEC06, 16'h0004);
    meas(3, 256);
    chk(32'(rs), 32'h0);
    $display("Divider and enable test done");
    finish_test();
  end
endmodule : fcp_test
